// File: discharge_temp_monitor.sv
/*
  Discharge temperature fault monitor: compares both thermistor codes
  against hot and cold limits with hysteresis, keeps two fault flags and,
  unless the override bit is set, drives the discharge FET and balancing
  control bits itself.
  Assumes thermistor codes and the sample strobe come from logic on the
  same clock, and that register strobes last one cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module discharge_temp_monitor
  import discharge_temp_pkg::*;
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr_en,
  input  wire logic [7:0]                  reg_wr_data,
  input  wire logic                        reg_rd_en,
  output var  logic [7:0]                  reg_rd_data,
  output var  logic                        reg_rd_valid,
  // thermistor conversions
  input  wire logic                        sample_valid,
  input  wire logic [CODE_W-1:0]           therm_code_a,
  input  wire logic [CODE_W-1:0]           therm_code_b,
  // other enabling conditions
  input  wire logic                        discharge_permit,
  input  wire logic                        balance_permit,
  // pack controls
  output var  logic                        discharge_fet_on,
  output var  logic                        cell_balance_on,
  output var  logic                        discharge_hot_fault_flag,
  output var  logic                        discharge_cold_fault_flag
);
  import discharge_temp_pkg::*;

  // ==========================================================
  // register port decode
  logic              bank_sel;
  logic              bank_wr;
  logic              bank_rd;
  logic [7:0]        bank_rd_data;
  logic [CODE_W-1:0] hot_limit;
  logic [CODE_W-1:0] hot_recover;
  logic [CODE_W-1:0] cold_limit;
  logic [CODE_W-1:0] cold_recover;

  always_comb
  begin
    bank_sel = (reg_addr[7:3] == DISCHARGE_HOT_LIMIT_LOW[7:3]);
    bank_wr  = reg_wr_en && bank_sel;
    bank_rd  = reg_rd_en && bank_sel;
  end

  threshold_bank u_bank (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .wr_en        (bank_wr),
    .rd_en        (bank_rd),
    .addr         (reg_addr[2:0]),
    .wr_data      (reg_wr_data),
    .rd_data      (bank_rd_data),
    .hot_limit    (hot_limit),
    .hot_recover  (hot_recover),
    .cold_limit   (cold_limit),
    .cold_recover (cold_recover)
  );

  // ==========================================================
  // sample capture and fault flags
  monitor_state_t    state;
  monitor_state_t    next_state;
  logic [CODE_W-1:0] code_a;
  logic [CODE_W-1:0] code_b;
  logic [CODE_W-1:0] next_code_a;
  logic [CODE_W-1:0] next_code_b;
  logic              next_hot_flag;
  logic              next_cold_flag;
  logic              hot_prev;
  logic              cold_prev;
  logic              next_hot_prev;
  logic              next_cold_prev;
  logic              hot_trip;
  logic              hot_clear;
  logic              cold_trip;
  logic              cold_clear;

  // both readings and all thresholds are raw 12-bit codes, no rescaling
  always_comb
  begin
    hot_trip   = (code_a < hot_limit) || (code_b < hot_limit);
    hot_clear  = (code_a > hot_recover) && (code_b > hot_recover);
    cold_trip  = (code_a > cold_limit) || (code_b > cold_limit);
    cold_clear = (code_a < cold_recover) && (code_b < cold_recover);
  end

  always_comb
  begin
    next_state     = state;
    next_code_a    = code_a;
    next_code_b    = code_b;
    next_hot_flag  = discharge_hot_fault_flag;
    next_cold_flag = discharge_cold_fault_flag;
    next_hot_prev  = hot_prev;
    next_cold_prev = cold_prev;
    case (state)
      ST_WAIT:
      begin
        if (sample_valid)
        begin
          next_code_a = therm_code_a;
          next_code_b = therm_code_b;
          next_state  = ST_EVAL;
        end
      end
      ST_EVAL:
      begin
        next_hot_prev  = discharge_hot_fault_flag;
        next_cold_prev = discharge_cold_fault_flag;
        // a trip wins over a clear if the limits overlap by mistake
        if (hot_trip)
          next_hot_flag = 1'b1;
        else if (discharge_hot_fault_flag && hot_clear)
          next_hot_flag = 1'b0;
        if (cold_trip)
          next_cold_flag = 1'b1;
        else if (discharge_cold_fault_flag && cold_clear)
          next_cold_flag = 1'b0;
        next_state = ST_ACT;
      end
      ST_ACT:
        next_state = ST_WAIT;
      default:
        next_state = ST_WAIT;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state                     <= ST_WAIT;
      code_a                    <= 12'h000;
      code_b                    <= 12'h000;
      discharge_hot_fault_flag  <= 1'b0;
      discharge_cold_fault_flag <= 1'b0;
      hot_prev                  <= 1'b0;
      cold_prev                 <= 1'b0;
    end
    else
    begin
      state                     <= next_state;
      code_a                    <= next_code_a;
      code_b                    <= next_code_b;
      discharge_hot_fault_flag  <= next_hot_flag;
      discharge_cold_fault_flag <= next_cold_flag;
      hot_prev                  <= next_hot_prev;
      cold_prev                 <= next_cold_prev;
    end
  end

  // ==========================================================
  // control bits and pack outputs
  logic discharge_fet_control;
  logic controller_cell_balancing;
  logic balancing_override;
  logic next_fet_control;
  logic next_balancing;
  logic next_override;
  logic next_fet_on;
  logic next_balance_on;
  logic any_fault;
  logic recovered;

  always_comb
  begin
    any_fault = discharge_hot_fault_flag || discharge_cold_fault_flag;
    recovered = (hot_prev && !discharge_hot_fault_flag) || (cold_prev && !discharge_cold_fault_flag);
    next_fet_control = discharge_fet_control;
    next_balancing   = controller_cell_balancing;
    next_override    = balancing_override;
    if (reg_wr_en && reg_addr == FET_CONTROL_ADDR)
      next_fet_control = reg_wr_data[FET_CONTROL_BIT];
    if (reg_wr_en && reg_addr == BALANCE_CONTROL_ADDR)
      next_balancing = reg_wr_data[BALANCE_BIT];
    if (reg_wr_en && reg_addr == OVERRIDE_CONTROL_ADDR)
      next_override = reg_wr_data[OVERRIDE_BIT];
    // automatic action beats a same-cycle software write; with the
    // override set the controller owns both bits outright
    if (state == ST_ACT && !balancing_override)
    begin
      if (any_fault)
      begin
        next_fet_control = 1'b0;
        next_balancing   = 1'b0;
      end
      else if (recovered)
      begin
        next_fet_control = 1'b1;
        next_balancing   = 1'b1;
      end
    end
    // other enabling conditions gate the pins, not the control bits
    next_fet_on     = discharge_fet_control && discharge_permit;
    next_balance_on = controller_cell_balancing && balance_permit;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      discharge_fet_control     <= FET_CONTROL_RST;
      controller_cell_balancing <= BALANCE_RST;
      balancing_override        <= OVERRIDE_RST;
      discharge_fet_on          <= 1'b0;
      cell_balance_on           <= 1'b0;
    end
    else
    begin
      discharge_fet_control     <= next_fet_control;
      controller_cell_balancing <= next_balancing;
      balancing_override        <= next_override;
      discharge_fet_on          <= next_fet_on;
      cell_balance_on           <= next_balance_on;
    end
  end

  // ==========================================================
  // read data: bank answers one edge late, so local data waits too
  logic [7:0] local_rd;
  logic [7:0] next_local_rd;
  logic       rd_from_bank;
  logic       next_rd_from_bank;
  logic       rd_pending;
  logic [7:0] next_reg_rd_data;

  always_comb
  begin
    next_local_rd = 8'h00;
    case (reg_addr)
      FAULT_STATUS_ADDR:
      begin
        next_local_rd[HOT_FLAG_BIT]  = discharge_hot_fault_flag;
        next_local_rd[COLD_FLAG_BIT] = discharge_cold_fault_flag;
      end
      FET_CONTROL_ADDR:      next_local_rd[FET_CONTROL_BIT] = discharge_fet_control;
      OVERRIDE_CONTROL_ADDR: next_local_rd[OVERRIDE_BIT]    = balancing_override;
      BALANCE_CONTROL_ADDR:  next_local_rd[BALANCE_BIT]     = controller_cell_balancing;
      default:               next_local_rd = 8'h00;
    endcase
    if (!reg_rd_en)
      next_local_rd = local_rd;
    next_rd_from_bank = reg_rd_en ? bank_sel : rd_from_bank;
    next_reg_rd_data  = rd_pending ? (rd_from_bank ? bank_rd_data : local_rd) : reg_rd_data;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      local_rd     <= 8'h00;
      rd_from_bank <= 1'b0;
      rd_pending   <= 1'b0;
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      local_rd     <= next_local_rd;
      rd_from_bank <= next_rd_from_bank;
      rd_pending   <= reg_rd_en;
      reg_rd_data  <= next_reg_rd_data;
      reg_rd_valid <= rd_pending;
    end
  end

  // ==========================================================
  // checks
  AST_HOT_SET: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_EVAL && hot_trip) |=> discharge_hot_fault_flag)
    else $error("hot flag not set after a reading below the hot limit");

  AST_HOT_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_EVAL && discharge_hot_fault_flag && hot_clear && !hot_trip) |=> !discharge_hot_fault_flag)
    else $error("hot flag not cleared after both readings recovered");

  AST_COLD_SET: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_EVAL && cold_trip) |=> discharge_cold_fault_flag)
    else $error("cold flag not set after a reading above the cold limit");

  AST_COLD_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_EVAL && discharge_cold_fault_flag && cold_clear && !cold_trip) |=> !discharge_cold_fault_flag)
    else $error("cold flag not cleared after both readings recovered");

  AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    (state != ST_EVAL) |=> ($stable(discharge_hot_fault_flag) && $stable(discharge_cold_fault_flag)))
    else $error("fault flag moved outside an evaluation");

  AST_HOT_SHUTOFF: assert property (@(posedge clock) disable iff (sys_rst)
    ($rose(discharge_hot_fault_flag) && !balancing_override)
      |=> (!discharge_fet_control && !controller_cell_balancing) ##2 !discharge_fet_on)
    else $error("hot fault did not switch off the discharge path");

  AST_COLD_SHUTOFF: assert property (@(posedge clock) disable iff (sys_rst)
    ($rose(discharge_cold_fault_flag) && !balancing_override) |=> ##1 !cell_balance_on)
    else $error("cold fault did not stop balancing");

  AST_RESTORE: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_ACT && recovered && !any_fault && !balancing_override)
      |=> (discharge_fet_control && controller_cell_balancing))
    else $error("recovery did not restore the discharge path");

  AST_OVERRIDE_FREEZE: assert property (@(posedge clock) disable iff (sys_rst)
    (balancing_override && !reg_wr_en) |=> ($stable(discharge_fet_control) && $stable(controller_cell_balancing)))
    else $error("control bits changed under override without a write");

  AST_READ_TIMING: assert property (@(posedge clock) disable iff (sys_rst)
    (reg_rd_en && reg_addr == DISCHARGE_HOT_LIMIT_LOW) |=> ##1 (reg_rd_valid && reg_rd_data == hot_limit[7:0]))
    else $error("hot limit low byte read back wrong or late");

endmodule : discharge_temp_monitor

`default_nettype wire

// File: discharge_temp_pkg.sv
/*
  Constants, register map and state codes shared by the discharge
  temperature fault monitor and its threshold byte bank.
  Assumes one 40 MHz clock and 12-bit thermistor codes.
*/
`default_nettype none

package discharge_temp_pkg;

  // ==========================================================
  // widths
  localparam int unsigned CODE_W    = 12;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned BANK_N    = 8;
  localparam int unsigned BANK_AW   = 3;

  // ==========================================================
  // register offsets
  localparam logic [7:0] DISCHARGE_HOT_LIMIT_LOW     = 8'h38;
  localparam logic [7:0] DISCHARGE_HOT_LIMIT_HIGH    = 8'h39;
  localparam logic [7:0] DISCHARGE_HOT_RECOVER_LOW   = 8'h3a;
  localparam logic [7:0] DISCHARGE_HOT_RECOVER_HIGH  = 8'h3b;
  localparam logic [7:0] DISCHARGE_COLD_LIMIT_LOW    = 8'h3c;
  localparam logic [7:0] DISCHARGE_COLD_LIMIT_HIGH   = 8'h3d;
  localparam logic [7:0] DISCHARGE_COLD_RECOVER_LOW  = 8'h3e;
  localparam logic [7:0] DISCHARGE_COLD_RECOVER_HIGH = 8'h3f;
  localparam logic [7:0] FAULT_STATUS_ADDR           = 8'h80;
  localparam logic [7:0] FET_CONTROL_ADDR            = 8'h86;
  localparam logic [7:0] OVERRIDE_CONTROL_ADDR       = 8'h87;
  localparam logic [7:0] BALANCE_CONTROL_ADDR        = 8'h88;

  // ==========================================================
  // field positions
  localparam int unsigned HOT_FLAG_BIT      = 4;
  localparam int unsigned COLD_FLAG_BIT     = 5;
  localparam int unsigned FET_CONTROL_BIT   = 0;
  localparam int unsigned OVERRIDE_BIT      = 5;
  localparam int unsigned BALANCE_BIT       = 0;
  localparam logic [7:0]  HIGH_BYTE_MASK    = 8'h0f;

  // ==========================================================
  // values after reset, bank entries in offset order
  localparam logic [7:0] HOT_LIMIT_LOW_RST     = 8'hb6;
  localparam logic [7:0] HOT_LIMIT_HIGH_RST    = 8'h04;
  localparam logic [7:0] HOT_RECOVER_LOW_RST   = 8'h3e;
  localparam logic [7:0] HOT_RECOVER_HIGH_RST  = 8'h05;
  localparam logic [7:0] COLD_LIMIT_LOW_RST    = 8'hf2;
  localparam logic [7:0] COLD_LIMIT_HIGH_RST   = 8'h0b;
  localparam logic [7:0] COLD_RECOVER_LOW_RST  = 8'h93;
  localparam logic [7:0] COLD_RECOVER_HIGH_RST = 8'h0a;
  localparam logic [7:0] BANK_RST [BANK_N] = '{
    HOT_LIMIT_LOW_RST, HOT_LIMIT_HIGH_RST, HOT_RECOVER_LOW_RST, HOT_RECOVER_HIGH_RST,
    COLD_LIMIT_LOW_RST, COLD_LIMIT_HIGH_RST, COLD_RECOVER_LOW_RST, COLD_RECOVER_HIGH_RST};
  localparam logic       FET_CONTROL_RST = 1'b1;
  localparam logic       OVERRIDE_RST    = 1'b0;
  localparam logic       BALANCE_RST     = 1'b1;

  // ==========================================================
  // evaluation sequencer
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_EVAL = 3'b010,
    ST_ACT  = 3'b100
  } monitor_state_t;

endpackage : discharge_temp_pkg

`default_nettype wire

// File: threshold_bank.sv
/*
  Eight-byte threshold store: four 12-bit limits split into low and
  high bytes, reserved high nibbles kept at zero, registered read data.
  Assumes the caller decodes the bank range and issues one-cycle strobes.
*/
`timescale 1ns/10ps
`default_nettype none

module threshold_bank
  import discharge_temp_pkg::*;
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // byte access
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  input  wire logic [BANK_AW-1:0]          addr,
  input  wire logic [BYTE_W-1:0]           wr_data,
  output var  logic [BYTE_W-1:0]           rd_data,
  // assembled thresholds
  output var  logic [CODE_W-1:0]           hot_limit,
  output var  logic [CODE_W-1:0]           hot_recover,
  output var  logic [CODE_W-1:0]           cold_limit,
  output var  logic [CODE_W-1:0]           cold_recover
);
  import discharge_temp_pkg::*;

  logic [BYTE_W-1:0] entry [BANK_N];
  logic [BYTE_W-1:0] next_rd_data;

  // ==========================================================
  // storage, one byte per entry
  genvar i;
  generate
    for (i = 0; i < BANK_N; i++)
    begin : g_entry
      logic [BYTE_W-1:0] next_byte;
      always_comb
      begin
        next_byte = entry[i];
        if (wr_en && addr == BANK_AW'(i))
          // odd entries are upper bytes: reserved nibble never stored
          next_byte = (i % 2 == 1) ? (wr_data & HIGH_BYTE_MASK) : wr_data;
      end
      always_ff @(posedge clock or posedge sys_rst)
      begin
        if (sys_rst)
          entry[i] <= BANK_RST[i];
        else
          entry[i] <= next_byte;
      end
    end
  endgenerate

  // ==========================================================
  // read port
  always_comb
  begin
    next_rd_data = rd_en ? entry[addr] : rd_data;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rd_data <= 8'h00;
    else
      rd_data <= next_rd_data;
  end

  always_comb
  begin
    hot_limit    = {entry[1][3:0], entry[0]};
    hot_recover  = {entry[3][3:0], entry[2]};
    cold_limit   = {entry[5][3:0], entry[4]};
    cold_recover = {entry[7][3:0], entry[6]};
  end

  // ==========================================================
  // checks
  AST_RESERVED_NIBBLE: assert property (@(posedge clock) disable iff (sys_rst)
    (rd_en && addr[0]) |=> (rd_data[7:4] == 4'h0))
    else $error("reserved nibble of an upper threshold byte read back nonzero");

  AST_LIMIT_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
    (wr_en && addr == 3'h4) |=> (cold_limit[7:0] == $past(wr_data)))
    else $error("cold limit low byte did not take the written value");

endmodule : threshold_bank

`default_nettype wire

// File: mcu_model.sv
/*
  Behavioural external controller on the register port.
  Assumes one-cycle strobes and reads answered by reg_rd_valid.
*/
`timescale 1ns/10ps
`default_nettype none

module mcu_model
  import discharge_temp_pkg::*;
#(
  parameter int LAG = 20
)
(
  // clock
  input  wire logic       clock,
  // register port
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr_en,
  output var  logic [7:0] reg_wr_data,
  output var  logic       reg_rd_en,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid,
  // fault watch
  input  wire logic       follow,
  input  wire logic [1:0] flags
);
  logic [1:0] last;

  initial
  begin
    reg_addr    = 8'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
    last        = 2'b00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge clock);
    reg_wr_en   <= 1'b0;
    // spare edge so a following strobe is never set in the same step
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge clock);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      #1;
      if (reg_rd_valid === 1'b1)
      begin
        d = reg_rd_data;
        break;
      end
    end
  endtask : rd

  // ==========================================================
  // override mode: follow each flag change with fet and balance bits
  initial
  forever
  begin
    @(posedge clock);
    if (follow === 1'b1 && flags !== last)
    begin
      last = flags;
      repeat (LAG) @(posedge clock);
      wr(FET_CONTROL_ADDR, {7'h00, ~|last});
      wr(BALANCE_CONTROL_ADDR, {7'h00, ~|last});
    end
  end
endmodule : mcu_model

`default_nettype wire

// File: testbench.sv
/*
  Self-checking bench for the discharge temperature fault monitor.
  Assumes the controller model owns the register port.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import discharge_temp_pkg::*;

  logic clock = 1'b0, sys_rst = 1'b1, sample_valid = 1'b0, follow = 1'b0;
  logic [CODE_W-1:0] code_a = 12'h600, code_b = 12'h600;
  logic [7:0] addr, wdata, rdata, d;
  logic wen, ren, rvalid, fet_on, bal_on, hot, cold;
  logic dis_ok = 1'b1, bal_ok = 1'b1;
  int errors = 0, n_compared = 0;

  initial forever #12.5 clock = ~clock;

  discharge_temp_monitor i_discharge_temp_monitor (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(addr), .reg_wr_en(wen), .reg_wr_data(wdata), .reg_rd_en(ren),
    .reg_rd_data(rdata), .reg_rd_valid(rvalid), .sample_valid(sample_valid),
    .therm_code_a(code_a), .therm_code_b(code_b), .discharge_permit(dis_ok),
    .balance_permit(bal_ok), .discharge_fet_on(fet_on), .cell_balance_on(bal_on),
    .discharge_hot_fault_flag(hot), .discharge_cold_fault_flag(cold));

  mcu_model #(.LAG(20)) i_mcu_model (.clock(clock), .reg_addr(addr), .reg_wr_en(wen),
    .reg_wr_data(wdata), .reg_rd_en(ren), .reg_rd_data(rdata), .reg_rd_valid(rvalid),
    .follow(follow), .flags({cold, hot}));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic samp(input logic [11:0] a, input logic [11:0] b);
    @(posedge clock);
    sample_valid <= 1'b1;
    code_a       <= a;
    code_b       <= b;
    @(posedge clock);
    sample_valid <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
  endtask : samp

  // ==========================================================
  task automatic t_reset_map;
    for (int i = 0; i < 8; i++)
    begin
      i_mcu_model.rd(8'h38 + 8'(i), d);
      check(d, BANK_RST[i]);
    end
    i_mcu_model.rd(8'h50, d);
    check(d, 16'h0000);
    i_mcu_model.wr(DISCHARGE_HOT_LIMIT_HIGH, 8'hf4);
    i_mcu_model.rd(DISCHARGE_HOT_LIMIT_HIGH, d);
    check(d, 16'h0004);
    $display("test reset_map done");
  endtask : t_reset_map

  task automatic t_hot;
    i_mcu_model.wr(DISCHARGE_HOT_LIMIT_LOW, 8'h00);
    i_mcu_model.wr(DISCHARGE_HOT_LIMIT_HIGH, 8'h05);
    samp(12'h600, 12'h500);
    check(hot, 1'b0);
    samp(12'h600, 12'h4ff);
    check({hot, fet_on, bal_on}, 3'b100);
    i_mcu_model.rd(FAULT_STATUS_ADDR, d);
    check(d, 16'h0010);
    i_mcu_model.rd(FET_CONTROL_ADDR, d);
    check(d, 16'h0000);
    samp(12'h520, 12'h600);
    check({hot, fet_on}, 2'b10);
    samp(12'h600, 12'h600);
    check({hot, fet_on, bal_on}, 3'b011);
    $display("test hot done");
  endtask : t_hot

  task automatic t_cold;
    i_mcu_model.wr(DISCHARGE_COLD_LIMIT_LOW, 8'hf0);
    i_mcu_model.rd(DISCHARGE_COLD_LIMIT_LOW, d);
    check(d, 16'h00f0);
    samp(12'h700, 12'hbf3);
    check({cold, fet_on, bal_on}, 3'b100);
    i_mcu_model.rd(FAULT_STATUS_ADDR, d);
    check(d, 16'h0020);
    samp(12'ha92, 12'ha93);
    check(cold, 1'b1);
    samp(12'ha92, 12'ha92);
    check({cold, fet_on, bal_on}, 3'b011);
    // other enabling conditions gate the pins even with no fault
    @(posedge clock);
    dis_ok <= 1'b0;
    bal_ok <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check({fet_on, bal_on}, 2'b00);
    @(posedge clock);
    dis_ok <= 1'b1;
    bal_ok <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check({fet_on, bal_on}, 2'b11);
    $display("test cold done");
  endtask : t_cold

  task automatic t_override;
    i_mcu_model.wr(OVERRIDE_CONTROL_ADDR, 8'h20);
    follow <= 1'b1;
    samp(12'h100, 12'h600);
    check({hot, fet_on, bal_on}, 3'b111);
    repeat (40) @(posedge clock);
    #1;
    check({fet_on, bal_on}, 2'b00);
    samp(12'h600, 12'h600);
    check({hot, fet_on}, 2'b00);
    repeat (40) @(posedge clock);
    #1;
    check({fet_on, bal_on}, 2'b11);
    follow <= 1'b0;
    $display("test override done");
  endtask : t_override

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset_map();
    t_hot();
    t_cold();
    t_override();
    wrap_up();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #(25 * 20000);
    errors++;
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
